// File: rtl/pcgs_pkg.sv
// Constants and types shared by the gauge sequencer device end and host end.
// Assumes one 100 MHz clock shared by both ends on their own clk ports; the link interface carries no clock.
package pcgs_pkg;
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned LEAD_TIME_MS     = 1000;
	localparam int unsigned LEAD_CYCLES      = (CLK_HZ / 1000) * LEAD_TIME_MS;
	localparam logic [6:0]  TARGET_ADDR      = 7'h55;
	localparam logic [1:0]  MODE_ACC         = 2'h0;
	localparam logic [1:0]  MODE_SOH         = 2'h1;
	localparam logic [1:0]  MODE_EOS         = 2'h2;
	localparam logic [15:0] SUB_GAUGE_START  = 16'h0011;
	localparam logic [15:0] SUB_GAUGE_STOP   = 16'h0012;
	localparam logic [15:0] SUB_RESET        = 16'h0041;
	localparam logic [1:0]  CMD_CONTROL      = 2'h0;
	localparam logic [1:0]  CMD_RD_STATUS    = 2'h1;
	localparam logic [1:0]  CMD_RD_CHARGE    = 2'h2;
	localparam logic [1:0]  CMD_WR_TEMP      = 2'h3;
	localparam logic [1:0]  CFG_MODE_LSB     = 2'h0;
	localparam int unsigned CFG_EXTDIV_BIT   = 2;
	localparam int unsigned CFG_TSRC_BIT     = 3;
	localparam int unsigned CFG_HTEMP_BIT    = 4;
	localparam logic [4:0]  CFG_RESET        = 5'h08;
	localparam int unsigned ST_INIT_BIT      = 0;
	localparam int unsigned ST_DONE_BIT      = 1;
	localparam int unsigned ST_EOS_BIT       = 2;
	localparam int unsigned ST_ACTIVE_BIT    = 3;
	localparam logic [7:0]  INIT_CYCLES      = 8'h10;
	localparam logic [7:0]  FINISH_CYCLES    = 8'h20;
	localparam logic [15:0] HREG_CMD         = 16'h0000;
	localparam logic [15:0] HREG_DATA        = 16'h0004;
	localparam logic [15:0] HREG_STATUS      = 16'h0008;
	localparam logic [15:0] HREG_RESULT      = 16'h000c;
	typedef enum logic [4:0] {
		PCGS_OFF    = 5'b00001,
		PCGS_INIT   = 5'b00010,
		PCGS_IDLE   = 5'b00100,
		PCGS_ACTIVE = 5'b01000,
		PCGS_FINISH = 5'b10000
	} pcgs_state_e;
endpackage

// File: rtl/pcgs_link_if.sv
// Link between the host end and the gauge end: power pin, command channel
// and alert line. Transport is abstracted as one-cycle command strobes.
`timescale 1ns/10ps
interface pcgs_link_if;
	logic        gauge_power_pin;
	logic        cmd_valid;
	logic [6:0]  cmd_addr;
	logic [1:0]  cmd_kind;
	logic [15:0] cmd_data;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic        alert_n;
	modport gauge (input gauge_power_pin, cmd_valid, cmd_addr, cmd_kind, cmd_data,
		output rsp_valid, rsp_data, alert_n);
	modport host (output gauge_power_pin, cmd_valid, cmd_addr, cmd_kind, cmd_data,
		input rsp_valid, rsp_data, alert_n);
endinterface

// File: rtl/pcgs_gauge.sv
// Gauge end: operating sequencer of the primary-cell gauge.
// Assumes the host keeps the command order and the end-of-service load timing.
// Summary of operation
// - Power pin low clears everything but the response data, no measuring
// - Mode field selects accumulator, health, end-of-service
// - Accumulator default; calibration only in accumulator
// - Accumulator counts charge only, no gauging results
// - After power-up set init flag, alert low
// - Status read clears alert; host then starts
// - Charge count since last start, readable anytime outside health mode
// - Stop finishes work, sets done, alert low
// - Health results readable without start; stop checks thresholds
// - Host starts one second before load pulse
// - Host stops right after pulse, no more pulses
// - After done in end-of-service, decision flag shown
// - Default direct cell, divider when bit set
// - Thermistor default, internal sensor when bit zero
// - Host temperature used when write bit set
// - Host resets after calibration via pin or command
// - Host keeps one mode in the field
// - Subcommand 0x0011 starts active gauging
// - Subcommand 0x0012 stops and finishes tasks
// - Answers only target address 1010101
`timescale 1ns/10ps
module pcgs_gauge (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Link
	pcgs_link_if.gauge              link,
	// Measurement side
	input  wire logic               discharge_tick,
	input  wire logic [15:0]        health_in,
	input  wire logic               eos_verdict_in,
	input  wire logic [15:0]        thermistor_temp,
	input  wire logic [15:0]        internal_temp,
	input  wire logic               calibrate_req,
	// Status to measurement side
	output logic                    measuring,
	output logic [1:0]              gauging_mode_select,
	output logic                    external_divider_select,
	output logic [15:0]             temp_used,
	output logic                    calibrating,
	output logic                    lifetime_store
);
	import pcgs_pkg::*;

	pcgs_state_e  state_r;
	logic [7:0]   wait_r;
	logic [4:0]   op_config_a;
	logic [15:0]  host_temp_r;
	logic [15:0]  passed_charge_count;
	logic         init_complete_flag;
	logic         done_flag_r;
	logic         end_of_service_flag;
	logic         alert_r;
	logic         rsp_valid_r;
	logic [15:0]  rsp_data_r;
	logic         lifetime_r;
	logic         powered;
	logic         hit;
	logic         start_cmd;
	logic         stop_cmd;
	logic         reset_cmd;
	logic         status_rd;
	logic [3:0]   battery_flags_reg;
	logic         accumulator_mode;
	logic         health_mode;

	assign powered          = link.gauge_power_pin;
	assign hit              = link.cmd_valid && (link.cmd_addr == TARGET_ADDR);
	assign start_cmd        = hit && link.cmd_kind == CMD_CONTROL
		&& link.cmd_data == SUB_GAUGE_START;
	assign stop_cmd         = hit && link.cmd_kind == CMD_CONTROL
		&& link.cmd_data == SUB_GAUGE_STOP;
	assign reset_cmd        = hit && link.cmd_kind == CMD_CONTROL
		&& link.cmd_data == SUB_RESET;
	assign status_rd        = hit && link.cmd_kind == CMD_RD_STATUS;
	assign accumulator_mode = op_config_a[CFG_MODE_LSB +: 2] == MODE_ACC;
	assign health_mode      = op_config_a[CFG_MODE_LSB +: 2] == MODE_SOH;
	assign battery_flags_reg = {state_r == PCGS_ACTIVE, end_of_service_flag,
		done_flag_r, init_complete_flag};

	// Sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= PCGS_OFF;
			wait_r  <= 8'h00;
		end else if (!powered || reset_cmd) begin
			state_r <= PCGS_OFF;
			wait_r  <= 8'h00;
		end else begin
			case (state_r)
				PCGS_OFF: begin
					state_r <= PCGS_INIT;
					wait_r  <= INIT_CYCLES;
				end
				PCGS_INIT: begin
					if (wait_r == 8'h00) begin
						state_r <= PCGS_IDLE;
					end else begin
						wait_r <= wait_r - 8'h01;
					end
				end
				PCGS_IDLE: begin
					if (start_cmd) begin
						state_r <= PCGS_ACTIVE;
					end else if (stop_cmd) begin
						state_r <= PCGS_FINISH;
						wait_r  <= FINISH_CYCLES;
					end
				end
				PCGS_ACTIVE: begin
					if (stop_cmd) begin
						state_r <= PCGS_FINISH;
						wait_r  <= FINISH_CYCLES;
					end
				end
				PCGS_FINISH: begin
					if (wait_r == 8'h00) begin
						state_r <= PCGS_IDLE;
					end else begin
						wait_r <= wait_r - 8'h01;
					end
				end
				default: state_r <= PCGS_OFF;
			endcase
		end
	end

	// Configuration, volatile: lost with power
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_config_a <= CFG_RESET;
			host_temp_r <= 16'h0000;
		end else if (!powered) begin
			op_config_a <= CFG_RESET;
			host_temp_r <= 16'h0000;
		end else if (hit && link.cmd_kind == CMD_WR_TEMP) begin
			if (op_config_a[CFG_HTEMP_BIT]) begin
				host_temp_r <= link.cmd_data;
			end else if (state_r == PCGS_IDLE) begin
				op_config_a <= link.cmd_data[4:0];
			end
		end
	end

	// Passed charge accumulates only while active
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			passed_charge_count <= 16'h0000;
		end else if (!powered || start_cmd) begin
			passed_charge_count <= 16'h0000;
		end else if (state_r == PCGS_ACTIVE && discharge_tick) begin
			passed_charge_count <= passed_charge_count + 16'h0001;
		end
	end

	// Flags; a new event wins over the clearing read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			init_complete_flag  <= 1'b0;
			done_flag_r         <= 1'b0;
			end_of_service_flag <= 1'b0;
			alert_r             <= 1'b0;
			lifetime_r          <= 1'b0;
		end else if (!powered) begin
			init_complete_flag  <= 1'b0;
			done_flag_r         <= 1'b0;
			end_of_service_flag <= 1'b0;
			alert_r             <= 1'b0;
			lifetime_r          <= 1'b0;
		end else begin
			lifetime_r <= 1'b0;
			// Start clears done first so that a done event in the same cycle still wins
			if (start_cmd) begin
				done_flag_r <= 1'b0;
			end
			if (state_r == PCGS_INIT && wait_r == 8'h00) begin
				init_complete_flag <= 1'b1;
				alert_r            <= 1'b1;
			end else if (state_r == PCGS_FINISH && wait_r == 8'h00) begin
				done_flag_r <= 1'b1;
				alert_r     <= 1'b1;
				lifetime_r  <= health_mode;
				if (op_config_a[CFG_MODE_LSB +: 2] == MODE_EOS) begin
					end_of_service_flag <= eos_verdict_in;
				end
			end else if (status_rd) begin
				alert_r <= 1'b0;
			end
		end
	end

	// Responses, one cycle after the command
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0000;
		end else begin
			rsp_valid_r <= powered && hit && (link.cmd_kind == CMD_RD_STATUS
				|| link.cmd_kind == CMD_RD_CHARGE);
			if (status_rd) begin
				rsp_data_r <= {12'h000, battery_flags_reg};
			end else if (hit && link.cmd_kind == CMD_RD_CHARGE) begin
				// Health mode reports its result with no gauging needed
				rsp_data_r <= health_mode ? health_in : passed_charge_count;
			end
		end
	end

	assign link.rsp_valid        = rsp_valid_r;
	assign link.rsp_data         = rsp_data_r;
	assign link.alert_n          = !alert_r;
	assign measuring             = state_r == PCGS_ACTIVE;
	assign gauging_mode_select   = op_config_a[CFG_MODE_LSB +: 2];
	assign external_divider_select = op_config_a[CFG_EXTDIV_BIT];
	assign temp_used = op_config_a[CFG_HTEMP_BIT] ? host_temp_r
		: (op_config_a[CFG_TSRC_BIT] ? thermistor_temp : internal_temp);
	assign calibrating    = calibrate_req && accumulator_mode && powered;
	assign lifetime_store = lifetime_r;
endmodule // pcgs_gauge

// File: rtl/pcgs_host.sv
// Host end: runs one gauging cycle in the configured mode on a software go.
// Assumes the gauge end answers reads one cycle after the command.
`timescale 1ns/10ps
module pcgs_host #(
	parameter int unsigned LEAD = pcgs_pkg::LEAD_CYCLES
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Software port
	input  wire logic [15:0]        addr,
	input  wire logic [15:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic [15:0]             rdata,
	// Load control
	output logic                    load_pulse,
	input  wire logic               load_end,
	// Link
	pcgs_link_if.host               link
);
	import pcgs_pkg::*;

	typedef enum logic [5:0] {
		H_IDLE  = 6'b000001, H_INIT = 6'b000010, H_CLEAR = 6'b000100,
		H_LEAD  = 6'b001000, H_LOAD = 6'b010000, H_DONE = 6'b100000
	} pcgs_hstate_e;

	pcgs_hstate_e state_r;
	logic [31:0]  cnt_r;
	logic [1:0]   mode_r;
	logic [15:0]  result_r;
	logic [15:0]  rdata_r;
	logic         cmd_v_r;
	logic [1:0]   kind_r;
	logic [15:0]  data_r;
	logic         power_r;
	logic [4:0]   cfg_r;
	logic [15:0]  temp_r;
	logic         temp_sent_r;
	logic         busy;

	assign busy = state_r != H_IDLE;

	// Sequence; stop for end-of-service comes right at load end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= H_IDLE;
			power_r <= 1'b0;
			cmd_v_r <= 1'b0;
			kind_r  <= CMD_CONTROL;
			data_r  <= 16'h0000;
			cnt_r   <= 32'h0;
			mode_r  <= MODE_ACC;
			result_r <= 16'h0000;
			cfg_r    <= CFG_RESET;
			temp_r   <= 16'h0000;
			temp_sent_r <= 1'b0;
		end else begin
			cmd_v_r <= 1'b0;
			if (link.rsp_valid) begin
				result_r <= link.rsp_data;
			end
			case (state_r)
				H_IDLE: begin
					if (wr && addr == HREG_CMD) begin
						mode_r  <= wdata[1:0];
						cfg_r   <= wdata[4:0];
						temp_sent_r <= 1'b0;
						power_r <= 1'b1;
						state_r <= H_INIT;
					end else if (wr && addr == HREG_DATA) begin
						temp_r <= wdata;
					end
				end
				H_INIT: begin
					if (!link.alert_n) begin
						// Config is only taken while the gauge idles, so it goes first
						cmd_v_r <= 1'b1;
						kind_r  <= CMD_WR_TEMP;
						data_r  <= {11'h000, cfg_r};
						state_r <= H_CLEAR;
					end
				end
				H_CLEAR: begin
					if (kind_r == CMD_WR_TEMP && !temp_sent_r && cfg_r[CFG_HTEMP_BIT]) begin
						cmd_v_r     <= 1'b1;
						data_r      <= temp_r;
						temp_sent_r <= 1'b1;
					end else if (kind_r == CMD_WR_TEMP) begin
						cmd_v_r <= 1'b1;
						kind_r  <= CMD_RD_STATUS;
					end else if (link.alert_n) begin
						cmd_v_r <= 1'b1;
						kind_r  <= CMD_CONTROL;
						data_r  <= SUB_GAUGE_START;
						cnt_r   <= LEAD;
						state_r <= H_LEAD;
					end
				end
				H_LEAD: begin
					if (cnt_r != 32'h0 && mode_r == MODE_EOS) begin
						cnt_r <= cnt_r - 32'h1;
					end else if (mode_r != MODE_EOS || load_end) begin
						cmd_v_r <= 1'b1;
						kind_r  <= CMD_CONTROL;
						data_r  <= SUB_GAUGE_STOP;
						state_r <= H_LOAD;
					end
				end
				H_LOAD: begin
					if (!link.alert_n) begin
						cmd_v_r <= 1'b1;
						kind_r  <= (mode_r == MODE_EOS) ? CMD_RD_STATUS : CMD_RD_CHARGE;
						state_r <= H_DONE;
					end
				end
				H_DONE: begin
					if (link.rsp_valid) begin
						power_r <= 1'b0;
						state_r <= H_IDLE;
					end
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 16'h0000;
		end else if (rd) begin
			case (addr)
				HREG_STATUS: rdata_r <= {14'h0000, !link.alert_n, busy};
				HREG_RESULT: rdata_r <= result_r;
				default:     rdata_r <= 16'h0000;
			endcase
		end
	end

	assign rdata                = rdata_r;
	assign load_pulse           = state_r == H_LEAD && mode_r == MODE_EOS && cnt_r == 32'h0;
	assign link.gauge_power_pin = power_r;
	assign link.cmd_valid       = cmd_v_r;
	assign link.cmd_addr        = TARGET_ADDR;
	assign link.cmd_kind        = kind_r;
	assign link.cmd_data        = data_r;
endmodule // pcgs_host

// File: verification/pcgs_sva.sv
// Checker on the link between the host end and the gauge end.
// Assumes one clock for both ends and the link signals passed in by name.
`timescale 1ns/10ps
module pcgs_sva
	import pcgs_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Link
	input wire logic        gauge_power_pin,
	input wire logic        cmd_valid,
	input wire logic [6:0]  cmd_addr,
	input wire logic [1:0]  cmd_kind,
	input wire logic [15:0] cmd_data,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic        alert_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic rd_any;
	logic st_rd;
	logic start;
	logic stop;
	assign take   = cmd_valid && cmd_addr == TARGET_ADDR && gauge_power_pin;
	assign rd_any = take && (cmd_kind == CMD_RD_STATUS || cmd_kind == CMD_RD_CHARGE);
	assign st_rd  = take && cmd_kind == CMD_RD_STATUS;
	assign start  = take && cmd_kind == CMD_CONTROL && cmd_data == SUB_GAUGE_START;
	assign stop   = take && cmd_kind == CMD_CONTROL && cmd_data == SUB_GAUGE_STOP;
	// Init takes 17 cycles; the window leaves slack for the pin register
	sequence s_init;
		alert_n [*4] ##[1:24] !alert_n;
	endsequence
	sequence s_finish;
		##[20:40] !alert_n;
	endsequence
	a_off_no_answer: assert property (!gauge_power_pin |=> !rsp_valid)
		else $error("answer while powered off");
	a_off_alert_high: assert property (!gauge_power_pin ##1 !gauge_power_pin |-> alert_n)
		else $error("alert low while powered off");
	a_answer_addressed: assert property (rsp_valid |-> $past(rd_any))
		else $error("answer without an addressed read");
	a_read_answered: assert property (rd_any |=> rsp_valid)
		else $error("read not answered");
	a_init_alert: assert property ($rose(gauge_power_pin) |-> s_init)
		else $error("no init alert after power up");
	a_status_clears: assert property (st_rd && !alert_n |=> ##[0:1] alert_n)
		else $error("status read left alert low");
	a_alert_holds: assert property (!alert_n && gauge_power_pin && !st_rd && !$past(st_rd)
		|=> !alert_n)
		else $error("alert released without status read");
	a_stop_done: assert property (stop |-> s_finish)
		else $error("no done alert after stop");
	a_start_quiet: assert property (start |=> alert_n [*8])
		else $error("alert soon after start");
endmodule // pcgs_sva

// File: verification/primary_cell_gauge_sequencer_tb.sv
// Testbench: host end and gauge end joined by the link, one run per mode.
// Assumes the host runs a full gauging cycle on a mode write to its command register.
`timescale 1ns/10ps
module primary_cell_gauge_sequencer_tb;
	import pcgs_pkg::*;
	localparam int unsigned LEAD = 10;
	localparam logic [15:0] HOST_TEMP = 16'h0d5e;
	logic clk, rstn, wr, rd, load_end, eos_in, cal_req, meas_d, lp_seen, lt_seen;
	logic tick = 1'b0;
	logic [15:0] addr, wdata, rdata, health, therm, itemp, temp_used, temp_seen, res;
	logic [15:0] ticks, lead, lp_cnt;
	logic [1:0] mode, mode_seen;
	logic load_pulse, measuring, ext_div, ext_seen, calibrating, cal_seen, lstore;
	int miscompares, total_checks;
	pcgs_link_if i_pcgs_link_if ();
	pcgs_gauge i_pcgs_gauge (.clk(clk), .rstn(rstn), .link(i_pcgs_link_if),
		.discharge_tick(tick), .health_in(health), .eos_verdict_in(eos_in),
		.thermistor_temp(therm), .internal_temp(itemp), .calibrate_req(cal_req),
		.measuring(measuring), .gauging_mode_select(mode), .external_divider_select(ext_div),
		.temp_used(temp_used), .calibrating(calibrating), .lifetime_store(lstore));
	pcgs_host #(.LEAD(LEAD)) i_pcgs_host (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .load_pulse(load_pulse), .load_end(load_end),
		.link(i_pcgs_link_if));
	pcgs_sva i_pcgs_sva (.clk(clk), .rstn(rstn),
		.gauge_power_pin(i_pcgs_link_if.gauge_power_pin),
		.cmd_valid(i_pcgs_link_if.cmd_valid), .cmd_addr(i_pcgs_link_if.cmd_addr),
		.cmd_kind(i_pcgs_link_if.cmd_kind), .cmd_data(i_pcgs_link_if.cmd_data),
		.rsp_valid(i_pcgs_link_if.rsp_valid), .rsp_data(i_pcgs_link_if.rsp_data),
		.alert_n(i_pcgs_link_if.alert_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Observes gauging and plays the load: the load ends four cycles into a pulse
	always @(posedge clk) begin
		tick <= ~tick;
		meas_d <= measuring;
		lp_cnt <= load_pulse ? lp_cnt + 16'h1 : 16'h0;
		load_end <= (lp_cnt == 16'h3);
		if (load_pulse)
			lp_seen <= 1'b1;
		if (lstore)
			lt_seen <= 1'b1;
		if (measuring && !meas_d) begin
			ticks <= {15'h0, tick};
			lead <= 16'h0;
			lp_seen <= 1'b0;
			lt_seen <= 1'b0;
		end else if (measuring) begin
			ticks <= ticks + {15'h0, tick};
			if (!load_pulse && !lp_seen)
				lead <= lead + 16'h1;
		end
		if (measuring) begin
			mode_seen <= mode;
			ext_seen <= ext_div;
			temp_seen <= temp_used;
			cal_seen <= calibrating;
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic sw_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic sw_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// One whole gauging cycle; waits on the busy bit under a bounded poll count
	task automatic run(input logic [4:0] m, output logic [15:0] r);
		logic [15:0] s;
		int n;
		n = 0;
		s = 16'h1;
		sw_wr(HREG_CMD, {11'h0, m});
		repeat (3) @(posedge clk);
		while (s[0] !== 1'b0 && n < 400) begin
			sw_rd(HREG_STATUS, s);
			n++;
		end
		if (n >= 400)
			miscompares++;
		sw_rd(HREG_RESULT, r);
	endtask
	initial begin
		{wr, rd, cal_req} = '0;
		{addr, wdata} = '0;
		eos_in = 1'b1;
		health = 16'h5a3c;
		therm = 16'h0b21;
		itemp = 16'h0c44;
		miscompares = 0;
		total_checks = 0;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		sw_wr(HREG_DATA, HOST_TEMP);
		for (int k = 0; k < 3; k++) begin
			cal_req <= 1'b1;
			therm <= therm + 16'h1;
			// Each run picks its own divider and temperature source beside the mode
			run((k == 0) ? 5'h08 : ((k == 1) ? 5'h05 : 5'h1a), res);
			chk({14'h0, mode_seen}, {14'h0, k[1:0]});
			chk({15'h0, ext_seen}, {15'h0, k == 1});
			chk(temp_seen, (k == 1) ? itemp : ((k == 2) ? HOST_TEMP : therm));
			chk({15'h0, lt_seen}, {15'h0, k == 1});
			chk({15'h0, measuring}, 16'h0);
			if (k[1:0] == MODE_ACC) begin
				chk(res, ticks);
				chk({15'h0, cal_seen}, 16'h1);
			end else begin
				chk({15'h0, cal_seen}, 16'h0);
			end
			if (k[1:0] == MODE_SOH)
				chk(res, health);
			if (k[1:0] == MODE_EOS) begin
				chk({15'h0, res[ST_EOS_BIT]}, 16'h1);
				chk({15'h0, res[ST_DONE_BIT]}, 16'h1);
				chk({15'h0, lead >= 16'(LEAD - 2) && lead <= 16'(LEAD + 3)}, 16'h1);
				chk({15'h0, lp_seen}, 16'h1);
			end
		end
		report_and_stop();
	end
	initial begin
		#100us;
		miscompares++;
		report_and_stop();
	end
endmodule // primary_cell_gauge_sequencer_tb
